// >>> hdl/ffrc_fifo_ctrl.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ffrc_fifo_ctrl #(
  parameter int DEPTH  = ffrc_pkg::DEPTH_DEF,
  parameter int AE_OFF = ffrc_pkg::AE_OFF_DEF,
  parameter int AF_OFF = ffrc_pkg::AF_OFF_DEF
) (
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  input  wire logic                        full_clear_n,
  input  wire logic                        partial_clear_n,
  input  wire logic                        write_clk_pin,
  input  wire logic                        read_clk_pin,
  input  wire logic                        write_en_n,
  input  wire logic                        read_en_n,
  input  wire logic                        replay_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        lookahead_serial_in,
  input  wire logic                        write_port_async_n,
  input  wire logic                        read_port_async_n,
  input  wire logic                        replay_latency_sel,
  input  wire logic                        endian_sel_n,
  input  wire logic                        flag_timing_sel,
  input  wire logic                        interspersed_parity_sel,
  input  wire logic                        bus_match_sel,
  input  wire logic                        output_width_sel,
  input  wire logic                        input_width_sel,
  input  wire logic [ffrc_pkg::DATA_W-1:0] data_in,
  output logic      [ffrc_pkg::DATA_W-1:0] data_out,
  output logic                             data_out_oe,
  output logic                             empty_flag_n,
  output logic                             full_flag_n,
  output logic                             output_ready_n,
  output logic                             input_ready_n,
  output logic                             almost_empty_flag_n,
  output logic                             almost_full_flag_n,
  output logic                             half_full_flag_n,
  output logic                             fall_through_mode,
  output logic                             cfg_endian_n,
  output logic                             cfg_flag_timing,
  output logic                             cfg_parity,
  output logic                             cfg_bus_match,
  output logic                             cfg_output_width,
  output logic                             cfg_input_width
);
  import ffrc_pkg::*;

  localparam int ADDR_W = $clog2(DEPTH);
  localparam logic [ADDR_W:0] DEPTH_C = (ADDR_W+1)'(DEPTH);
  localparam logic [ADDR_W:0] HALF_C  = (ADDR_W+1)'(DEPTH / 2);
  localparam logic [ADDR_W:0] AE_C    = (ADDR_W+1)'(AE_OFF);
  localparam logic [ADDR_W:0] AF_C    = (ADDR_W+1)'(DEPTH - AF_OFF);
  localparam logic [ADDR_W:0] ONE_C   = (ADDR_W+1)'(1);

  logic [CTRL_W-1:0] ctl_pins;
  logic [CTRL_W-1:0] ctl;
  logic [DATA_W-1:0] data_s;

  // All control pins but output enable cross into core_clk; the raw clears and lookahead strap also act directly, output enable acts only directly
  assign ctl_pins = {input_width_sel, output_width_sel, bus_match_sel, interspersed_parity_sel,
                     flag_timing_sel, endian_sel_n, replay_latency_sel, read_port_async_n,
                     write_port_async_n, lookahead_serial_in, partial_clear_n, full_clear_n,
                     replay_n, read_en_n, write_en_n, read_clk_pin, write_clk_pin};

  ffrc_pin_sync #(.WIDTH(CTRL_W), .RESET_VAL(CTRL_RST)) u_ctl_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_in   (ctl_pins),
    .pin_out  (ctl)
  );

  // Data takes the same path so it lines up with the strobe edge
  ffrc_pin_sync #(.WIDTH(DATA_W), .RESET_VAL('0)) u_data_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_in   (data_in),
    .pin_out  (data_s)
  );

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [ADDR_W:0]   wr_ptr_q, wr_ptr_d;
  logic [ADDR_W:0]   rd_ptr_q, rd_ptr_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic              ov_q, ov_d;
  logic              wr_pin_q, rd_pin_q;
  ffrc_rstate_t      rs_q, rs_d;
  logic              fall_through_mode_q, fall_through_mode_d;
  logic              wasync_n_q, wasync_n_d;
  logic              rasync_n_q, rasync_n_d;
  logic              zl_q, zl_d;
  logic [5:0]        cfg_q, cfg_d;
  logic [1:0]        ae_q, ae_d;
  logic [1:0]        af_q, af_d;

  logic              clr_n, wr_rise, rd_rise, wen_act, ren_act, wr_go;
  logic [ADDR_W:0]   count;
  logic              full, empty;

  // Strobe edges and enables; an async port ignores its enable pin
  always_comb begin
    clr_n   = ctl[C_FCLR] & ctl[C_PCLR];
    wr_rise = ctl[C_WR] & ~wr_pin_q;
    rd_rise = ctl[C_RD] & ~rd_pin_q;
    wen_act = ~wasync_n_q | ~ctl[C_WEN];
    ren_act = ~rasync_n_q | ~ctl[C_REN];
    count   = wr_ptr_q - rd_ptr_q;
    full    = (count == DEPTH_C);
    empty   = (count == '0);
    wr_go   = clr_n & wr_rise & wen_act & ~full;
  end

  // Configuration capture: follows the straps while full clear is low, then holds
  always_comb begin
    fall_through_mode_d     = fall_through_mode_q;
    wasync_n_d = wasync_n_q;
    rasync_n_d = rasync_n_q;
    zl_d       = zl_q;
    cfg_d      = cfg_q;
    if (!ctl[C_FCLR]) begin
      fall_through_mode_d     = ctl[C_LA];
      wasync_n_d = ctl[C_WA];
      rasync_n_d = ctl[C_RA];
      zl_d       = ctl[C_RM];
      cfg_d      = {ctl[C_IW], ctl[C_OW], ctl[C_BM], ctl[C_IP], ctl[C_PFM], ctl[C_BE]};
    end
  end

  // Pointer, output register and replay sequencing
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    dout_d   = dout_q;
    ov_d     = ov_q;
    rs_d     = rs_q;
    if (!clr_n) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      dout_d   = '0;
      ov_d     = 1'b0;
      rs_d     = FFRC_RS_IDLE;
    end else begin
      if (wr_go) begin
        wr_ptr_d = wr_ptr_q + ONE_C;
      end
      case (rs_q)
        FFRC_RS_IDLE: begin
          if (rd_rise && !ctl[C_RPL]) begin
            rd_ptr_d = '0;
            ov_d     = 1'b0;
            rs_d     = FFRC_RS_SETUP;
            if (zl_q) begin
              dout_d   = mem_q[0];
              rd_ptr_d = ONE_C;
              ov_d     = fall_through_mode_q;
            end
          end else if (!fall_through_mode_q) begin
            if (rd_rise && ren_act && !empty) begin
              dout_d   = mem_q[rd_ptr_q[ADDR_W-1:0]];
              rd_ptr_d = rd_ptr_q + ONE_C;
            end
          end else if (!ov_q) begin
            if (!empty) begin
              dout_d   = mem_q[rd_ptr_q[ADDR_W-1:0]];
              rd_ptr_d = rd_ptr_q + ONE_C;
              ov_d     = 1'b1;
            end
          end else if (rd_rise && ren_act) begin
            if (!empty) begin
              dout_d   = mem_q[rd_ptr_q[ADDR_W-1:0]];
              rd_ptr_d = rd_ptr_q + ONE_C;
            end else begin
              ov_d = 1'b0;
            end
          end
        end
        FFRC_RS_SETUP: begin
          rs_d = FFRC_RS_IDLE;
        end
        default: begin
          rs_d = FFRC_RS_IDLE;
        end
      endcase
    end
  end

  // Almost flags pass two stages so a replay reaches them two edges later
  always_comb begin
    ae_d = {ae_q[0], ~(count <= AE_C)};
    af_d = {af_q[0], ~(count >= AF_C)};
    if (!clr_n) begin
      ae_d = 2'b00;
      af_d = 2'b11;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      dout_q     <= '0;
      ov_q       <= 1'b0;
      rs_q       <= FFRC_RS_IDLE;
      wr_pin_q   <= 1'b0;
      rd_pin_q   <= 1'b0;
      fall_through_mode_q     <= FALL_THROUGH_MODE_RST;
      wasync_n_q <= ASYNC_RST;
      rasync_n_q <= ASYNC_RST;
      zl_q       <= ZL_RST;
      cfg_q      <= '0;
      ae_q       <= 2'b00;
      af_q       <= 2'b11;
    end else begin
      wr_ptr_q   <= wr_ptr_d;
      rd_ptr_q   <= rd_ptr_d;
      dout_q     <= dout_d;
      ov_q       <= ov_d;
      rs_q       <= rs_d;
      wr_pin_q   <= ctl[C_WR];
      rd_pin_q   <= ctl[C_RD];
      fall_through_mode_q     <= fall_through_mode_d;
      wasync_n_q <= wasync_n_d;
      rasync_n_q <= rasync_n_d;
      zl_q       <= zl_d;
      cfg_q      <= cfg_d;
      ae_q       <= ae_d;
      af_q       <= af_d;
    end
  end

  // Storage array; not reset, contents are meaningless until written
  always_ff @(posedge core_clk) begin
    if (wr_go) begin
      mem_q[wr_ptr_q[ADDR_W-1:0]] <= data_s;
    end
  end

  logic raw_clr_n, std_mode, busy;

  // Raw clear pins override the outputs at once so no clock is needed
  always_comb begin
    raw_clr_n = full_clear_n & partial_clear_n;
    std_mode  = full_clear_n ? ~fall_through_mode_q : ~lookahead_serial_in;
    busy      = (rs_q == FFRC_RS_SETUP);
  end

  // Empty, full and half flags come straight from the pointers, so both strobes move them in one cycle; almost flags lag two edges
  assign empty_flag_n        = std_mode ? (raw_clr_n & ~empty & ~busy) : 1'b1;
  assign full_flag_n         = std_mode ? (~raw_clr_n | ~full) : 1'b1;
  assign output_ready_n      = std_mode ? 1'b1 : (~raw_clr_n | ~ov_q | busy);
  assign input_ready_n       = std_mode ? 1'b1 : (raw_clr_n & full);
  assign half_full_flag_n    = ~raw_clr_n | ~(count > HALF_C);
  assign almost_empty_flag_n = raw_clr_n & ae_q[1];
  assign almost_full_flag_n  = ~raw_clr_n | af_q[1];

  // Output register zeroed by either clear pin without waiting for the clock
  assign data_out    = raw_clr_n ? dout_q : '0;
  assign data_out_oe = ~output_enable_n;

  assign fall_through_mode = fall_through_mode_q;
  assign cfg_endian_n      = cfg_q[0];
  assign cfg_flag_timing   = cfg_q[1];
  assign cfg_parity        = cfg_q[2];
  assign cfg_bus_match     = cfg_q[3];
  assign cfg_output_width  = cfg_q[4];
  assign cfg_input_width   = cfg_q[5];

endmodule
`default_nettype wire

// >>> pkg/ffrc_pkg.sv
`default_nettype none
package ffrc_pkg;

  // Word width and default depth of the storage array
  localparam int DATA_W      = 36;
  localparam int DEPTH_DEF   = 1024;
  localparam int AE_OFF_DEF  = 7;
  localparam int AF_OFF_DEF  = 7;

  // Bit positions in the synchronised control-pin vector
  localparam int C_WR   = 0;   // Write clock or write strobe pin
  localparam int C_RD   = 1;   // Read clock or read strobe pin
  localparam int C_WEN  = 2;   // Write enable, active low
  localparam int C_REN  = 3;   // Read enable, active low
  localparam int C_RPL  = 4;   // Replay request, active low
  localparam int C_FCLR = 5;   // Full clear, active low
  localparam int C_PCLR = 6;   // Partial clear, active low
  localparam int C_LA   = 7;   // Lookahead strap
  localparam int C_WA   = 8;   // Write port async strap, active low
  localparam int C_RA   = 9;   // Read port async strap, active low
  localparam int C_RM   = 10;  // Replay latency strap
  localparam int C_BE   = 11;  // Endian strap, active low
  localparam int C_PFM  = 12;  // Flag timing strap
  localparam int C_IP   = 13;  // Interspersed parity strap
  localparam int C_BM   = 14;  // Bus match strap
  localparam int C_OW   = 15;  // Output width strap
  localparam int C_IW   = 16;  // Input width strap
  localparam int CTRL_W = 17;

  // Idle levels seen before the pins are sampled: clears asserted, enables off
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h0_009c;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Reset values of the captured configuration
  localparam logic FALL_THROUGH_MODE_RST  = 1'b0;
  localparam logic ASYNC_RST = 1'b1;
  localparam logic ZL_RST    = 1'b0;

  // Read-side sequencer
  typedef enum logic [0:0] {
    FFRC_RS_IDLE,
    FFRC_RS_SETUP
  } ffrc_rstate_t;

endpackage
`default_nettype wire

// >>> hdl/ffrc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a bit changes once stages two and three agree
module ffrc_pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  import ffrc_pkg::*;

  logic [WIDTH-1:0] s1_q, s2_q, s3_q;
  logic [WIDTH-1:0] out_q, out_d;

  // First stage feeds only the second; the filter looks at stages two and three
  always_comb begin
    out_d = (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q  <= RESET_VAL;
      s2_q  <= RESET_VAL;
      s3_q  <= RESET_VAL;
      out_q <= RESET_VAL;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;

endmodule
`default_nettype wire

// >>> testbench/ffrc_fifo_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks on clear levels, strap capture and output hold
module ffrc_fifo_ctrl_assertions (
  input wire logic                        core_clk,
  input wire logic                        arst_n,
  input wire logic                        full_clear_n,
  input wire logic                        partial_clear_n,
  input wire logic                        read_clk_pin,
  input wire logic                        output_enable_n,
  input wire logic                        lookahead_serial_in,
  input wire logic                        endian_sel_n,
  input wire logic                        flag_timing_sel,
  input wire logic                        interspersed_parity_sel,
  input wire logic                        bus_match_sel,
  input wire logic                        output_width_sel,
  input wire logic                        input_width_sel,
  input wire logic [ffrc_pkg::DATA_W-1:0] data_out,
  input wire logic                        data_out_oe,
  input wire logic                        empty_flag_n,
  input wire logic                        full_flag_n,
  input wire logic                        output_ready_n,
  input wire logic                        input_ready_n,
  input wire logic                        almost_empty_flag_n,
  input wire logic                        almost_full_flag_n,
  input wire logic                        half_full_flag_n,
  input wire logic                        fall_through_mode,
  input wire logic                        cfg_endian_n,
  input wire logic                        cfg_flag_timing,
  input wire logic                        cfg_parity,
  input wire logic                        cfg_bus_match,
  input wire logic                        cfg_output_width,
  input wire logic                        cfg_input_width
);
  import ffrc_pkg::*;

  // Strap pins and their captured copies in the same order
  wire logic [6:0] straps = {lookahead_serial_in, endian_sel_n, flag_timing_sel, interspersed_parity_sel,
                             bus_match_sel, output_width_sel, input_width_sel};
  wire logic [6:0] cfgs   = {fall_through_mode, cfg_endian_n, cfg_flag_timing, cfg_parity, cfg_bus_match,
                             cfg_output_width, cfg_input_width};
  wire logic [3:0] ef_ff  = {empty_flag_n, full_flag_n, output_ready_n, input_ready_n};
  wire logic       lvls   = !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n && data_out == '0;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Clear held with steady straps, then released long enough to pass the synchroniser
  sequence s_clr_held;
    (!full_clear_n && $stable(straps))[*6];
  endsequence
  sequence s_clr_gone;
    full_clear_n[*6];
  endsequence

  chk_strap_latch: assert property (s_clr_held ##1 s_clr_gone |-> cfgs == $past(straps, 7))
    else $error("captured straps differ from pins held in clear");
  chk_oe_comb: assert property (data_out_oe == !output_enable_n)
    else $error("bus drive enable does not follow output enable");
  chk_fclr_lvls: assert property (!full_clear_n |-> lvls)
    else $error("levels wrong during full clear");
  chk_pclr_lvls: assert property (!partial_clear_n |-> lvls)
    else $error("levels wrong during partial clear");
  chk_fclr_std: assert property (!full_clear_n && !lookahead_serial_in |-> ef_ff == 4'h7)
    else $error("standard flags wrong during full clear");
  chk_fclr_ft: assert property (!full_clear_n && lookahead_serial_in |-> ef_ff == 4'he)
    else $error("ready flags wrong during full clear");
  chk_pclr_mode: assert property (full_clear_n && !partial_clear_n |-> ef_ff == (fall_through_mode ? 4'he : 4'h7))
    else $error("partial clear lost the active mode");
  chk_out_hold: assert property ((full_clear_n && partial_clear_n && !read_clk_pin && !fall_through_mode)[*8]
                                 |-> $stable(data_out))
    else $error("output word moved without a read edge");
endmodule
`default_nettype wire

// >>> testbench/ffrc_pin_agent.sv
`timescale 1ns/1ps
`default_nettype none
// Writer and reader on the far side; pins are paced slower than the synchroniser
module ffrc_pin_agent (
  input  wire logic                        core_clk,
  output logic                             write_clk_pin,
  output logic                             read_clk_pin,
  output logic                             write_en_n,
  output logic                             read_en_n,
  output logic                             replay_n,
  output logic [ffrc_pkg::DATA_W-1:0]      data_in
);
  import ffrc_pkg::*;
  logic tie_en = 1'b0;

  // Pins stand still low outside transfers, enables and replay off
  initial begin
    write_clk_pin = 1'b0;
    read_clk_pin  = 1'b0;
    write_en_n    = 1'b1;
    read_en_n     = 1'b1;
    replay_n      = 1'b1;
    data_in       = '0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Strobe ports: both enables tied active from here on
  task automatic strobe_mode();
    tie_en = 1'b1;
    write_en_n <= 1'b0;
    read_en_n  <= 1'b0;
  endtask

  // One write; the word stands five cycles before the rising edge and ten after it
  // Starts on a fresh edge so back-to-back calls never drive a pin twice in one step
  task automatic put(input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    data_in    <= d;
    write_en_n <= 1'b0;
    hold(5);
    write_clk_pin <= 1'b1;
    hold(5);
    write_clk_pin <= 1'b0;
    hold(5);
    write_en_n <= ~tie_en;
    data_in    <= ~d; // Stale word inverted so nothing leans on it
  endtask

  // One read edge, replay optionally held low across it
  task automatic take(input logic en_n, input logic rt_n);
    @(posedge core_clk);
    read_en_n <= en_n & ~tie_en;
    replay_n  <= rt_n;
    hold(5);
    read_clk_pin <= 1'b1;
    hold(5);
    read_clk_pin <= 1'b0;
    hold(5);
    read_en_n <= ~tie_en;
    replay_n  <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_ffrc_fifo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Clears, straps, streaming, replay and strobe ports, checked at the pins
module test_ffrc_fifo_ctrl;
  import ffrc_pkg::*;
  logic              core_clk        = 1'b0;
  logic              arst_n          = 1'b0;
  logic              full_clear_n    = 1'b1;
  logic              partial_clear_n = 1'b1;
  logic              output_enable_n = 1'b0;
  logic [9:0]        strap           = 10'h1ab; // Lookahead, async wr, async rd, latency, six echoed
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic              write_clk_pin, read_clk_pin, write_en_n, read_en_n, replay_n, data_out_oe;
  logic              empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  logic              almost_empty_flag_n, almost_full_flag_n, half_full_flag_n, fall_through_mode;
  logic              cfg_endian_n, cfg_flag_timing, cfg_parity, cfg_bus_match, cfg_output_width, cfg_input_width;
  int                err_count  = 0;
  int                n_compared = 0;
  int                cyc        = 0;
  wire logic [6:0]   flg = {empty_flag_n, full_flag_n, output_ready_n, input_ready_n, almost_empty_flag_n,
                            almost_full_flag_n, half_full_flag_n};
  wire logic [6:0]   cfg = {fall_through_mode, cfg_endian_n, cfg_flag_timing, cfg_parity, cfg_bus_match,
                            cfg_output_width, cfg_input_width};

  // Small depth keeps the half and almost thresholds within reach
  ffrc_fifo_ctrl #(.DEPTH(16), .AE_OFF(2), .AF_OFF(2)) i_dut (
    .core_clk, .arst_n, .full_clear_n, .partial_clear_n, .write_clk_pin, .read_clk_pin, .write_en_n,
    .read_en_n, .replay_n, .output_enable_n, .lookahead_serial_in(strap[9]), .write_port_async_n(strap[8]),
    .read_port_async_n(strap[7]), .replay_latency_sel(strap[6]), .endian_sel_n(strap[5]),
    .flag_timing_sel(strap[4]), .interspersed_parity_sel(strap[3]), .bus_match_sel(strap[2]),
    .output_width_sel(strap[1]), .input_width_sel(strap[0]), .data_in, .data_out, .data_out_oe,
    .empty_flag_n, .full_flag_n, .output_ready_n, .input_ready_n, .almost_empty_flag_n, .almost_full_flag_n,
    .half_full_flag_n, .fall_through_mode, .cfg_endian_n, .cfg_flag_timing, .cfg_parity, .cfg_bus_match,
    .cfg_output_width, .cfg_input_width);

  ffrc_pin_agent i_agt (.core_clk, .write_clk_pin, .read_clk_pin, .write_en_n, .read_en_n, .replay_n, .data_in);

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  task automatic cmp_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input logic [6:0] got, input logic [6:0] exp);
    cmp_data({29'h0, got}, {29'h0, exp});
  endtask

  function automatic logic [DATA_W-1:0] w(input int k);
    return 36'h9_0000_0000 | (36'(k) * 36'h0_0001_0101);
  endfunction

  // Hold a clear with the given straps, check forced levels, then release
  task automatic clr(input logic full, input logic [9:0] s, input logic [6:0] lv);
    @(posedge core_clk);
    strap           <= s;
    full_clear_n    <= !full;
    partial_clear_n <= full;
    repeat (4) @(posedge core_clk);
    #1;
    cmp_flags(flg, lv);
    cmp_data(data_out, '0);
    repeat (4) @(posedge core_clk);
    full_clear_n    <= 1'b1;
    partial_clear_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic rd(input logic en_n, input logic rt_n, input logic [DATA_W-1:0] exp);
    i_agt.take(en_n, rt_n);
    #1;
    cmp_data(data_out, exp);
  endtask

  task automatic end_of_test();
    $display("errors=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cycle ceiling against a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    clr(1'b1, 10'h1ab, 7'h3b);
    strap[5:0] <= 6'h14;
    for (int k = 0; k < 10; k++) i_agt.put(w(k));
    #1;
    cmp_flags(flg, 7'h7e);
    cmp_flags(cfg, 7'h2b);
    rd(1'b0, 1'b1, w(0));
    rd(1'b0, 1'b1, w(1));
    cmp_flags(flg, 7'h7f);
    @(posedge core_clk);
    output_enable_n <= 1'b1;
    @(posedge core_clk);
    #1;
    cmp_flags({6'h0, data_out_oe}, 7'h00);
    @(posedge core_clk);
    output_enable_n <= 1'b0;
    @(posedge core_clk);
    #1;
    cmp_flags({6'h0, data_out_oe}, 7'h01);
    clr(1'b0, 10'h194, 7'h3b);
    cmp_flags(cfg, 7'h2b);
    for (int k = 20; k < 24; k++) i_agt.put(w(k));
    for (int k = 20; k < 23; k++) rd(1'b0, 1'b1, w(k));
    rd(1'b1, 1'b0, w(22));
    cmp_flags(flg, 7'h7f);
    rd(1'b0, 1'b1, w(20));
    rd(1'b0, 1'b1, w(21));
    clr(1'b1, 10'h3d4, 7'h73);
    for (int k = 30; k < 34; k++) i_agt.put(w(k));
    #1;
    cmp_data(data_out, w(30));
    cmp_flags(flg, 7'h67);
    rd(1'b0, 1'b1, w(31));
    rd(1'b0, 1'b1, w(32));
    rd(1'b0, 1'b0, w(30));
    cmp_flags(flg, 7'h67);
    rd(1'b0, 1'b1, w(31));
    clr(1'b0, 10'h3d4, 7'h73);
    i_agt.strobe_mode();
    clr(1'b1, 10'h014, 7'h3b);
    i_agt.put(w(40));
    i_agt.put(w(41));
    #1;
    cmp_flags(flg, 7'h7b);
    rd(1'b0, 1'b1, w(40));
    rd(1'b0, 1'b1, w(41));
    cmp_flags(flg, 7'h3b);
    end_of_test();
  end
endmodule

bind ffrc_fifo_ctrl ffrc_fifo_ctrl_assertions i_chk (
  .core_clk, .arst_n, .full_clear_n, .partial_clear_n, .read_clk_pin, .output_enable_n, .lookahead_serial_in,
  .endian_sel_n, .flag_timing_sel, .interspersed_parity_sel, .bus_match_sel, .output_width_sel,
  .input_width_sel, .data_out, .data_out_oe, .empty_flag_n, .full_flag_n, .output_ready_n, .input_ready_n,
  .almost_empty_flag_n, .almost_full_flag_n, .half_full_flag_n, .fall_through_mode, .cfg_endian_n,
  .cfg_flag_timing, .cfg_parity, .cfg_bus_match, .cfg_output_width, .cfg_input_width);
`default_nettype wire
